// [common/dout_pkg.sv]
// constants, state type and timing counts for the output board bus front end
// assumes a 100 MHz core clock; all bus pins arrive asynchronous to it
package dout_pkg;
    // base addresses at the default switch setting
    localparam logic [15:0] DATA_BASE_DEF = 16'hFF00;
    localparam logic [15:0] CTRL_BASE_DEF = 16'hFFF0;
    // lowest address bit compared for each window
    localparam int DATA_CMP_LSB = 3;
    localparam int CTRL_CMP_LSB = 1;
    // short I/O address modifier codes
    localparam logic [5:0] AM_SHORT_SUP = 6'h2D;
    localparam logic [5:0] AM_SHORT_NP  = 6'h29;
    // control register bit positions and reset values
    localparam int   TM_BIT = 7;
    localparam int   FL_BIT = 6;
    localparam logic TM_RST = 1'b1;
    localparam logic FL_RST = 1'b1;
    localparam logic [7:0] ODR_RST = 8'h00;
    // timing: strobe setup before latching, acknowledge delay
    localparam int CLK_NS          = 10;
    localparam int STROBE_SETUP_NS = 20;
    localparam int ACK_DELAY_NS    = 10;
    localparam int STB_CYC = (STROBE_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACK_CYC = (ACK_DELAY_NS + CLK_NS - 1) / CLK_NS;
    // bus cycle states, gray along idle-setup-ack-done
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SETUP = 2'b01,
        ST_ACK   = 2'b11,
        ST_DONE  = 2'b10
    } bus_state_t;
endpackage : dout_pkg

// [common/odr_port_if.sv]
// carrier between the bus front end and the output data register store
// assumes both ends share one clock
`timescale 1ns/1ps
interface odr_port_if;
    logic [7:0]  we;
    logic [63:0] wdata;
    logic [63:0] rdata;
    modport ctrl (output we, output wdata, input rdata);
    modport mem  (input we, input wdata, output rdata);
endinterface : odr_port_if

// [dv/dout_bus_front_tb.sv]
// self-checking bench for the output board bus front end
// assumes default switch bases; the master model makes every bus cycle
`timescale 1ns/1ps
module dout_bus_front_tb;
    import dout_pkg::*;
    logic        clk    = 1'b0;
    logic        rst_n  = 1'b0;
    logic        jumper = 1'b0;
    wire  [15:1] addr;
    wire  [5:0]  am;
    wire  [31:0] d_in, d_out;
    wire         as_n, ds0_n, ds1_n, lword_n, write_n, d_oe, dtack_out, dtack_oe;
    wire         dsel_n, csel_n, bsel_n, gs0_n, gs1_n, glw_n, gd0_n, gd1_n, swap_n;
    wire  [63:0] field_out;
    wire         field_en, test_mode_n, fail_lamp;
    int          failures   = 0;
    int          num_checks = 0;
    logic [31:0] rd;
    logic        ok;
    int          lat;
    logic [5:0]  seen = '0; // data sel, ctrl sel, swap, delayed strobe, data drive, longword
    logic        bad  = 1'b0;

    initial begin
        forever #5 clk = ~clk;
    end

    vme_master_model i_master (.clk(clk), .addr(addr), .am(am), .as_n(as_n), .ds0_n(ds0_n),
        .ds1_n(ds1_n), .lword_n(lword_n), .write_n(write_n), .d_in(d_in), .d_out(d_out),
        .d_oe(d_oe), .dtack_oe(dtack_oe));

    dout_bus_front i_dut (.clk(clk), .rst_n(rst_n), .vme_addr(addr), .vme_am(am),
        .vme_as_n(as_n), .vme_ds0_n(ds0_n), .vme_ds1_n(ds1_n), .vme_lword_n(lword_n),
        .vme_write_n(write_n), .vme_d_in(d_in), .vme_d_out(d_out), .vme_d_oe(d_oe),
        .vme_dtack_out(dtack_out), .vme_dtack_oe(dtack_oe), .privilege_jumper(jumper),
        .data_reg_select_n(dsel_n), .ctrl_reg_select_n(csel_n), .board_select_n(bsel_n),
        .gated_strobe0_n(gs0_n), .gated_strobe1_n(gs1_n), .gated_longword_n(glw_n),
        .gated_strobe0_delayed_n(gd0_n), .gated_strobe1_delayed_n(gd1_n),
        .word_lane_swap_n(swap_n), .field_out(field_out), .field_out_en(field_en),
        .test_mode_n(test_mode_n), .fail_lamp(fail_lamp));

    // sticky watch of decode terms, sampled mid-cycle where they are settled
    always @(negedge clk) begin
        if (dsel_n === 1'b0) seen[0] = 1'b1;
        if (csel_n === 1'b0) seen[1] = 1'b1;
        if (swap_n === 1'b0) seen[2] = 1'b1;
        if (gd0_n === 1'b0 || gd1_n === 1'b0) seen[3] = 1'b1;
        if (d_oe === 1'b1) seen[4] = 1'b1;
        if (glw_n === 1'b0) seen[5] = 1'b1;
        if (glw_n === 1'b0 && bsel_n !== 1'b0) bad = 1'b1;
        if (dtack_oe === 1'b1 && dtack_out !== 1'b0) bad = 1'b1;
        if (bsel_n !== (dsel_n & csel_n)) bad = 1'b1;
        if ((gs0_n === 1'b0 || gs1_n === 1'b0) && bsel_n !== 1'b0) bad = 1'b1;
        if ((gd0_n === 1'b0 && gs0_n !== 1'b0) || (gd1_n === 1'b0 && gs1_n !== 1'b0))
            bad = 1'b1;
    end

    task automatic check(input string name, input logic [63:0] seen_v, input logic [63:0] exp_v);
        num_checks++;
        if (seen_v !== exp_v) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp_v, seen_v);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    // state right after reset: outputs off, lamp lit, registers clear
    task automatic t_reset();
        check("test_mode_n", test_mode_n, 0);
        check("fail_lamp", fail_lamp, 1);
        check("field_out_en", field_en, 0);
        check("field_out", field_out, 0);
        check("dtack_idle", dtack_oe, 0);
    endtask : t_reset

    // every byte written alone, lane by strobe, then read back as longwords
    task automatic t_bytes();
        for (int i = 0; i < 8; i++) begin
            i_master.xfer(1, DATA_BASE_DEF + 16'(i), AM_SHORT_SUP, i[0] ? 2'b10 : 2'b01, 1,
                          {16'h0, {2{8'hA0 + 8'(i)}}}, rd, ok, lat);
            check("byte_ack", ok, 1);
            check("ack_fast", lat <= 8, 1);
        end
        check("field_bytes", field_out, 64'hA0A1A2A3A4A5A6A7);
        check("drivers_off", field_en, 0);
        check("seen_data_sel", seen[0], 1);
        check("seen_swap", seen[2], 1);
        check("seen_delayed", seen[3], 1);
        i_master.xfer(0, DATA_BASE_DEF, AM_SHORT_SUP, 2'b00, 0, 0, rd, ok, lat);
        check("long_rd0", rd, 32'hA0A1A2A3);
        i_master.xfer(0, DATA_BASE_DEF + 16'h4, AM_SHORT_SUP, 2'b00, 0, 0, rd, ok, lat);
        check("long_rd1", rd, 32'hA4A5A6A7);
        check("seen_data_drive", seen[4], 1);
        check("seen_longword", seen[5], 1);
    endtask : t_bytes

    // longword and word writes, word reads from both internal halves
    task automatic t_words();
        i_master.xfer(1, DATA_BASE_DEF + 16'h4, AM_SHORT_SUP, 2'b00, 0, 32'h01234567,
                      rd, ok, lat);
        i_master.xfer(1, DATA_BASE_DEF + 16'h2, AM_SHORT_SUP, 2'b00, 1, 32'h89AB, rd, ok, lat);
        check("field_words", field_out, 64'hA0A189AB01234567);
        i_master.xfer(0, DATA_BASE_DEF + 16'h4, AM_SHORT_SUP, 2'b00, 1, 0, rd, ok, lat);
        check("word_rd_hi", rd[15:0], 16'h0123);
        i_master.xfer(0, DATA_BASE_DEF + 16'h6, AM_SHORT_SUP, 2'b00, 1, 0, rd, ok, lat);
        check("word_rd_lo", rd[15:0], 16'h4567);
    endtask : t_words

    // control register: upper byte ignored, lower byte drives mode bits, no read data
    task automatic t_ctrl();
        seen = '0;
        i_master.xfer(1, CTRL_BASE_DEF, AM_SHORT_SUP, 2'b01, 1, 32'hFF00, rd, ok, lat);
        check("upper_ignored", test_mode_n, 0);
        check("seen_ctrl_sel", seen[1], 1);
        i_master.xfer(1, CTRL_BASE_DEF + 16'h1, AM_SHORT_SUP, 2'b10, 1, 0, rd, ok, lat);
        check("tm_off", test_mode_n, 1);
        check("fl_off", fail_lamp, 0);
        check("drivers_on", field_en, 1);
        i_master.xfer(0, CTRL_BASE_DEF, AM_SHORT_SUP, 2'b00, 1, 0, rd, ok, lat);
        check("ctrl_rd_nodrive", seen[4], 0);
        i_master.xfer(1, CTRL_BASE_DEF, AM_SHORT_SUP, 2'b00, 1, 32'h0080, rd, ok, lat);
        check("tm_word", {test_mode_n, fail_lamp, field_en}, 3'b000);
        i_master.xfer(1, DATA_BASE_DEF + 16'h7, AM_SHORT_SUP, 2'b10, 1, 32'h5A5A, rd, ok, lat);
        i_master.xfer(0, DATA_BASE_DEF + 16'h6, AM_SHORT_SUP, 2'b00, 1, 0, rd, ok, lat);
        check("test_store", {field_out[7:0], rd[7:0]}, 16'h5A5A);
    endtask : t_ctrl

    // wrong modifier or address is ignored; the jumper swaps the accepted modifier
    task automatic t_refuse();
        i_master.xfer(1, DATA_BASE_DEF, AM_SHORT_NP, 2'b01, 1, 32'h1111, rd, ok, lat);
        check("np_refused", ok, 0);
        i_master.xfer(1, 16'hFE00, AM_SHORT_SUP, 2'b01, 1, 32'h1111, rd, ok, lat);
        check("addr_refused", ok, 0);
        check("no_write", field_out[63:56], 8'hA0);
        @(posedge clk);
        jumper <= 1'b1;
        repeat (6) @(posedge clk);
        i_master.xfer(1, DATA_BASE_DEF, AM_SHORT_NP, 2'b01, 1, 32'h3C00, rd, ok, lat);
        check("np_ok", {ok, field_out[63:56]}, 9'h13C);
        i_master.xfer(1, DATA_BASE_DEF, AM_SHORT_SUP, 2'b01, 1, 32'h1100, rd, ok, lat);
        check("sup_refused", ok, 0);
        check("decode_terms", bad, 0);
    endtask : t_refuse

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        t_reset();
        t_bytes();
        t_words();
        t_ctrl();
        t_refuse();
        check("ack_timeouts", i_master.ack_miss, 3);
        check("release_hang", i_master.rel_hang, 0);
        end_sim();
    end
endmodule : dout_bus_front_tb

// [dv/vme_master_model.sv]
// bus master model issuing short I/O cycles to the output board front end
// assumes one shared clock; pins change only just after a rising edge
`timescale 1ns/1ps
module vme_master_model (
    // clock
    input  wire logic        clk,
    // bus pins towards the slave
    output logic      [15:1] addr    = '1,
    output logic      [5:0]  am      = '1,
    output logic             as_n    = 1'b1,
    output logic             ds0_n   = 1'b1,
    output logic             ds1_n   = 1'b1,
    output logic             lword_n = 1'b1,
    output logic             write_n = 1'b1,
    output wire logic [31:0] d_in,
    // answers from the slave
    input  wire logic [31:0] d_out,
    input  wire logic        d_oe,
    input  wire logic        dtack_oe
);
    logic [31:0] wd_r   = '0;
    logic [31:0] last_r = '0;
    logic        drv_r  = 1'b0;
    // unanswered requests and acknowledges never let go, read by the bench at the end
    int          ack_miss = 0;
    int          rel_hang = 0;
    // an undriven data bus shows the inverse of its last level, never a stale match
    assign d_in = drv_r ? wd_r : (d_oe ? d_out : ~last_r);
    always @(posedge clk) begin
        last_r <= d_in;
    end
    // one whole cycle: request held until acknowledge sampled or 30 clocks pass, then released
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [5:0] m,
                        input logic [1:0] ds_n, input logic lw_n, input logic [31:0] wd,
                        output logic [31:0] rd, output logic ok, output int lat);
        int n;
        ok  = 1'b0;
        rd  = '0;
        lat = 0;
        @(posedge clk);
        addr    <= a[15:1];
        am      <= m;
        write_n <= !wr;
        lword_n <= lw_n;
        wd_r    <= wd;
        drv_r   <= wr;
        as_n    <= 1'b0;
        ds1_n   <= ds_n[1];
        ds0_n   <= ds_n[0];
        for (n = 0; n < 30 && !ok; n++) begin
            @(posedge clk);
            lat = n + 1;
            if (dtack_oe === 1'b1) begin
                ok = 1'b1;
                rd = d_out;
            end
        end
        if (!ok) ack_miss++;
        as_n  <= 1'b1;
        ds0_n <= 1'b1;
        ds1_n <= 1'b1;
        drv_r <= 1'b0;
        // a new cycle waits up to 20 clocks for the slave to let go of the acknowledge, then starts anyway
        for (n = 0; n < 20 && dtack_oe !== 1'b0; n++) @(posedge clk);
        if (dtack_oe !== 1'b0) rel_hang++;
        repeat (2) @(posedge clk);
    endtask : xfer
endmodule : vme_master_model

// [src/dout_bus_front.sv]
// short I/O slave front end of a 64-channel digital output board
// assumes bus pins are asynchronous and are filtered here on the core clock
// What this block does
// - data select when address hits data base
// - control select when address hits control base
// - board select is OR of both selects
// - gate both strobes and longword with board select
// - latch writes only on delayed gated strobes
// - lane swap moves upper internal half to D0-15
// - jumper picks supervisory or non-privileged short I/O
// - default bases FF00 data, FFF0 control
// - test mode and fail lamp from control bits
// - acknowledge after the shortest selectable delay
// - reset sets test mode and fail lamp
// - data regs by longword, word or byte
// - control reg write only, word or bytes
// - test mode stores data, field outputs disabled
`timescale 1ns/1ps
module dout_bus_front
    import dout_pkg::*;
#(
    parameter logic [15:0] DATA_BASE = DATA_BASE_DEF,
    parameter logic [15:0] CTRL_BASE = CTRL_BASE_DEF
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // bus address and control pins
    input  wire logic [15:1] vme_addr,
    input  wire logic [5:0]  vme_am,
    input  wire logic        vme_as_n,
    input  wire logic        vme_ds0_n,
    input  wire logic        vme_ds1_n,
    input  wire logic        vme_lword_n,
    input  wire logic        vme_write_n,
    // bus data, two-way
    input  wire logic [31:0] vme_d_in,
    output wire logic [31:0] vme_d_out,
    output wire logic        vme_d_oe,
    // acknowledge, open drain
    output wire logic        vme_dtack_out,
    output wire logic        vme_dtack_oe,
    // address modifier jumper, high when fitted
    input  wire logic        privilege_jumper,
    // decode terms
    output wire logic        data_reg_select_n,
    output wire logic        ctrl_reg_select_n,
    output wire logic        board_select_n,
    output wire logic        gated_strobe0_n,
    output wire logic        gated_strobe1_n,
    output wire logic        gated_longword_n,
    output wire logic        gated_strobe0_delayed_n,
    output wire logic        gated_strobe1_delayed_n,
    output wire logic        word_lane_swap_n,
    // field side
    output wire logic [63:0] field_out,
    output wire logic        field_out_en,
    output wire logic        test_mode_n,
    output wire logic        fail_lamp
);
    localparam int SW = 59;

    logic [SW-1:0] pin_raw;
    logic [SW-1:0] s1_r, s2_r, s3_r, filt_r;
    logic [SW-1:0] filt_nxt;
    logic [15:1]   a_q;
    logic [5:0]    am_q;
    logic          as_n_q, ds0_n_q, ds1_n_q, lw_n_q, wr_n_q, jmp_q;
    logic [31:0]   d_q;

    // three-stage filter; a bit moves only when stages two and three agree
    assign pin_raw  = {vme_addr, vme_am, vme_as_n, vme_ds0_n, vme_ds1_n,
                       vme_lword_n, vme_write_n, privilege_jumper, vme_d_in};
    assign filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r   <= '1;
            s2_r   <= '1;
            s3_r   <= '1;
            filt_r <= '1;
        end else begin
            s1_r   <= pin_raw;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            filt_r <= filt_nxt;
        end
    end
    assign {a_q, am_q, as_n_q, ds0_n_q, ds1_n_q, lw_n_q, wr_n_q, jmp_q, d_q} = filt_r;

    // address modifier and window decode
    logic       am_ok, data_hit, ctrl_hit, bsel;
    logic [5:0] am_want;
    assign am_want  = jmp_q ? AM_SHORT_NP : AM_SHORT_SUP;
    assign am_ok    = (am_q == am_want) && !as_n_q;
    assign data_hit = am_ok && (a_q[15:DATA_CMP_LSB] == DATA_BASE[15:DATA_CMP_LSB]);
    assign ctrl_hit = am_ok && (a_q[15:CTRL_CMP_LSB] == CTRL_BASE[15:CTRL_CMP_LSB]);
    assign bsel     = data_hit || ctrl_hit;
    assign data_reg_select_n = !data_hit;
    assign ctrl_reg_select_n = !ctrl_hit;
    assign board_select_n    = !bsel;

    // strobes and longword enter the board only while selected
    assign gated_strobe0_n  = !(bsel && !ds0_n_q);
    assign gated_strobe1_n  = !(bsel && !ds1_n_q);
    assign gated_longword_n = !(bsel && !lw_n_q);

    // delayed strobes give data time through the lanes before latching
    logic [1:0] gd_n;
    strobe_delay #(
        .DEPTH (STB_CYC)
    ) u_delay (
        .clk   (clk),
        .rst_n (rst_n),
        .in_n  ({gated_strobe1_n, gated_strobe0_n}),
        .out_n (gd_n)
    );
    assign gated_strobe0_delayed_n = gd_n[0];
    assign gated_strobe1_delayed_n = gd_n[1];

    // upper internal half rides the low lanes for a word or byte at A1=0
    logic        swap, a1, a2;
    logic [31:0] idb_w, idb_r;
    logic [31:0] dout_nxt;
    assign a1   = a_q[1];
    assign a2   = a_q[2];
    assign swap = data_hit && gated_longword_n && !a1;
    assign word_lane_swap_n = !swap;
    assign idb_w = swap ? {d_q[15:0], d_q[15:0]} : d_q;

    // register store
    odr_port_if odr ();
    output_regs u_regs (
        .clk   (clk),
        .rst_n (rst_n),
        .port  (odr.mem)
    );
    assign idb_r    = a2 ? odr.rdata[31:0] : odr.rdata[63:32];
    assign dout_nxt = swap ? {16'h0000, idb_r[31:16]} : idb_r;

    // bus cycle sequencing
    bus_state_t st_r, st_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic       any_gs, settled, ack_last, wr_fire, rel;
    assign any_gs   = !gated_strobe0_n || !gated_strobe1_n;
    // all present strobes have passed the delay
    assign settled  = any_gs && (gd_n == {gated_strobe1_n, gated_strobe0_n});
    assign ack_last = (cnt_r == 4'(ACK_CYC - 1));
    assign wr_fire  = (st_r == ST_SETUP) && settled && (cnt_r == 4'h0) && !wr_n_q;
    assign rel      = ds0_n_q && ds1_n_q;

    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            ST_IDLE: begin
                cnt_nxt = 4'h0;
                if (bsel && any_gs) begin
                    st_nxt = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (!any_gs) begin
                    st_nxt = ST_IDLE;
                end else if (settled && ack_last) begin
                    st_nxt = ST_ACK;
                end else if (settled) begin
                    cnt_nxt = cnt_r + 4'h1;
                end
            end
            ST_ACK: begin
                if (rel) begin
                    st_nxt = ST_DONE;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r  <= ST_IDLE;
            cnt_r <= 4'h0;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // read data captured as the acknowledge starts; control reg reads stay undriven
    logic [31:0] dout_r;
    logic        doe_r;
    logic        to_ack;
    assign to_ack = (st_r == ST_SETUP) && (st_nxt == ST_ACK);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_r <= 32'h0000_0000;
            doe_r  <= 1'b0;
        end else begin
            if (to_ack) begin
                dout_r <= dout_nxt;
            end
            doe_r <= to_ack ? (wr_n_q && data_hit) : (doe_r && (st_nxt == ST_ACK));
        end
    end
    assign vme_d_out     = dout_r;
    assign vme_d_oe      = doe_r;
    assign vme_dtack_out = 1'b0;
    assign vme_dtack_oe  = (st_r == ST_ACK);

    // byte write enables: lane k of the selected longword group
    logic [3:0] lane_en;
    logic       long_q;
    assign long_q  = !gated_longword_n;
    assign lane_en = long_q ? {4{!gd_n[0] && !gd_n[1]}}
                            : {a1 && !gd_n[0], a1 && !gd_n[1],
                               !a1 && !gd_n[0], !a1 && !gd_n[1]};
    for (genvar i = 0; i < 8; i++) begin : g_we
        assign odr.we[i] = wr_fire && data_hit && (a2 == 1'(i / 4))
                           && lane_en[i % 4];
    end
    assign odr.wdata = {idb_w, idb_w};

    // control register: only the low byte (odd strobe) holds live bits
    logic tm_r, fl_r;
    logic ctrl_wr;
    assign ctrl_wr = wr_fire && ctrl_hit && !gd_n[0];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tm_r <= TM_RST;
            fl_r <= FL_RST;
        end else if (ctrl_wr) begin
            tm_r <= d_q[TM_BIT];
            fl_r <= d_q[FL_BIT];
        end
    end
    // stored data stays readable in test mode; only the drivers are cut
    assign field_out    = odr.rdata;
    assign field_out_en = !tm_r;
    assign test_mode_n  = !tm_r;
    assign fail_lamp    = fl_r;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_wait_ack;
        (st_r == ST_SETUP) && settled && !wr_n_q;
    endsequence
    sequence s_ctrl_wr;
        ctrl_wr ##1 1'b1;
    endsequence

    a_data_sel_hit: assert property (
        (!as_n_q && am_ok && a_q[15:3] == DATA_BASE[15:3]) |-> !data_reg_select_n)
        else $error("data select missed on matching address");
    a_ctrl_sel_hit: assert property (
        !ctrl_reg_select_n |-> (a_q[15:1] == CTRL_BASE[15:1]) && !as_n_q)
        else $error("control select without matching address");
    a_board_sel_or: assert property (
        board_select_n == (data_reg_select_n && ctrl_reg_select_n))
        else $error("board select not the OR of selects");
    a_gated_idle: assert property (
        board_select_n |-> gated_strobe0_n && gated_strobe1_n && gated_longword_n)
        else $error("gated strobe active while unselected");
    a_strobe_delay: assert property (
        $fell(gated_strobe0_delayed_n) |-> $past(!gated_strobe0_n, 2) && !gated_strobe0_n)
        else $error("delayed strobe asserted too early");
    a_lane_swap: assert property (
        (!word_lane_swap_n && odr.we[0]) |-> odr.wdata[63:56] == d_q[15:8])
        else $error("swapped write not on low lanes");
    a_am_type: assert property (
        !board_select_n |-> am_q == (jmp_q ? AM_SHORT_NP : AM_SHORT_SUP))
        else $error("selected with wrong address modifier");
    a_ctrl_bits: assert property (
        s_ctrl_wr |-> test_mode_n == !$past(d_q[TM_BIT]) && fail_lamp == $past(d_q[FL_BIT]))
        else $error("control bits not taken from write");
    a_ack_delay: assert property (
        s_wait_ack |-> ##[1:2] vme_dtack_oe || !(!ds0_n_q || !ds1_n_q))
        else $error("acknowledge too late");
    a_test_outs: assert property (
        !test_mode_n |-> !field_out_en)
        else $error("field outputs enabled in test mode");
    a_no_ack_idle: assert property (
        (st_r == ST_IDLE) |=> !vme_dtack_oe)
        else $error("acknowledge without a selected cycle");

    // read lanes follow the acknowledge; the write only control register never drives
    a_read_drive: assert property (
        (to_ack && data_hit && wr_n_q) |=> vme_d_oe && vme_dtack_oe)
        else $error("data read not driven with acknowledge");
    a_ctrl_nodrive: assert property (
        (to_ack && ctrl_hit) |=> !vme_d_oe)
        else $error("control register read drove the bus");
    a_write_gate: assert property (
        (|odr.we) |-> !gated_strobe0_delayed_n || !gated_strobe1_delayed_n)
        else $error("register write without a delayed strobe");
    a_ack_start: assert property (
        $rose(vme_dtack_oe) |-> $past(settled))
        else $error("acknowledge began before strobes settled");
endmodule : dout_bus_front

// [src/output_regs.sv]
// eight byte output data register store, byte i sits at bits 63-8i downward
// assumes write enables are one-cycle pulses from the bus front end
`timescale 1ns/1ps
module output_regs
    import dout_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    odr_port_if.mem  port
);
    // one byte register per entry; rdata is the stored value itself
    for (genvar i = 0; i < 8; i++) begin : g_byte
        logic [7:0] byte_r;
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                byte_r <= ODR_RST;
            end else if (port.we[i]) begin
                byte_r <= port.wdata[63-8*i -: 8];
            end
        end
        assign port.rdata[63-8*i -: 8] = byte_r;
    end
endmodule : output_regs

// [src/strobe_delay.sv]
// delays the assertion of two active-low strobes by DEPTH clocks
// negation passes straight through so a cycle never outlives its strobe
`timescale 1ns/1ps
module strobe_delay #(
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // strobes
    input  wire logic [1:0] in_n,
    output wire logic [1:0] out_n
);
    logic [1:0] sh_r [DEPTH];

    // shift chain, each stage holds both strobes
    for (genvar k = 0; k < DEPTH; k++) begin : g_stage
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                sh_r[k] <= 2'h3;
            end else begin
                sh_r[k] <= (k == 0) ? in_n : sh_r[(k == 0) ? 0 : k-1];
            end
        end
    end

    assign out_n = in_n | sh_r[DEPTH-1];
endmodule : strobe_delay
